/* File: gpio_pkg.sv */
// Constants and types shared by the general purpose I/O port
package gpio_pkg;

  // Port geometry
  localparam int PIN_W = 6;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 3;

  // Register offsets on the plain register port
  localparam logic [ADDR_W-1:0] OFS_PIN_LEVELS = 3'h0;
  localparam logic [ADDR_W-1:0] OFS_OUTPUT_LATCH = 3'h1;
  localparam logic [ADDR_W-1:0] OFS_DIRECTION = 3'h2;
  localparam logic [ADDR_W-1:0] OFS_ANALOG_SELECT = 3'h3;
  localparam logic [ADDR_W-1:0] OFS_REMAP_SELECT = 3'h4;
  localparam logic [ADDR_W-1:0] OFS_LEVELS_SET = 3'h5;
  localparam logic [ADDR_W-1:0] OFS_LEVELS_CLEAR = 3'h6;

  // Field positions and fixed bits
  localparam int INPUT_ONLY_BIT = 3;
  localparam logic [PIN_W-1:0] INPUT_ONLY_MASK = 6'h08;

  // Values after reset
  localparam logic [PIN_W-1:0] DIRECTION_RESET = 6'h3F;
  localparam logic [PIN_W-1:0] ANALOG_SELECT_RESET = 6'h3F;
  localparam logic [PIN_W-1:0] OUTPUT_LATCH_RESET = 6'h00;
  localparam logic [PIN_W-1:0] REMAP_SELECT_RESET = 6'h00;
  localparam logic [DATA_W-1:0] READ_DATA_RESET = 8'h00;

  // Cycle counts
  localparam int SYNC_STAGES = 2;

  // Register file state of the port controller
  typedef struct packed {
    logic [PIN_W-1:0] latch;
    logic [PIN_W-1:0] direction;
    logic [PIN_W-1:0] analog_sel;
    logic [PIN_W-1:0] remap_sel;
    logic [PIN_W-1:0] analog_active;
    logic [DATA_W-1:0] rdata;
  } port_state_t;

endpackage : gpio_pkg

/* File: pad_if.sv */
// Carrier between the port controller and its pad-side modules
`timescale 1ns/1ns
interface pad_if;
  import gpio_pkg::*;
  logic [PIN_W-1:0] direction;
  logic [PIN_W-1:0] latch;
  logic [PIN_W-1:0] remap_sel;
  logic [PIN_W-1:0] analog_sel;
  logic [PIN_W-1:0] levels;

  modport ctrl (output direction, output latch, output remap_sel, output analog_sel,
    input levels);
  modport drv (input direction, input latch, input remap_sel);
  modport smp (input analog_sel, output levels);
endinterface : pad_if

/* File: pin_sampler.sv */
// Two-stage pin level synchroniser with digital input gating
`timescale 1ns/1ns
module pin_sampler
  import gpio_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic [PIN_W-1:0] i_pin_in,
  pad_if.smp pads
);

  typedef struct packed {
    logic [PIN_W-1:0] stage1;
    logic [PIN_W-1:0] stage2;
  } sampler_state_t;

  sampler_state_t state_reg;
  sampler_state_t state_next;
  logic [PIN_W-1:0] buffered;

  // Input buffer per pin, switched off while the pin is analog
  for (genvar b = 0; b < PIN_W; b++) begin : g_buffer
    assign buffered[b] = i_pin_in[b] & ~pads.analog_sel[b];
  end

  // First stage feeds only the second stage
  always_comb begin
    state_next = state_reg;
    state_next.stage1 = buffered;
    state_next.stage2 = state_reg.stage1;
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign pads.levels = state_reg.stage2;

endmodule : pin_sampler

/* File: pin_driver.sv */
// Per-pin output source selection and driver enable
`timescale 1ns/1ns
module pin_driver
  import gpio_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic [PIN_W-1:0] i_periph_out,
  input wire logic [PIN_W-1:0] i_analog_out_en,
  pad_if.drv pads,
  output logic [PIN_W-1:0] o_pin_out,
  output logic [PIN_W-1:0] o_pin_oe
);

  typedef struct packed {
    logic [PIN_W-1:0] pin_out;
    logic [PIN_W-1:0] pin_oe;
  } driver_state_t;

  driver_state_t state_reg;
  driver_state_t state_next;
  logic [PIN_W-1:0] source;
  logic [PIN_W-1:0] enable;

  // Source mux and enable per pin; analog output wins over all digital drive
  for (genvar b = 0; b < PIN_W; b++) begin : g_pin
    assign source[b] = pads.remap_sel[b] ? i_periph_out[b] : pads.latch[b];
    if (b == INPUT_ONLY_BIT) begin : g_input_only
      assign enable[b] = 1'b0;
    end else begin : g_io
      assign enable[b] = ~pads.direction[b] & ~i_analog_out_en[b];
    end
  end

  always_comb begin
    state_next = state_reg;
    state_next.pin_out = source;
    state_next.pin_oe = enable;
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign o_pin_out = state_reg.pin_out;
  assign o_pin_oe = state_reg.pin_oe;

endmodule : pin_driver

/* File: gpio_port.sv */
// General purpose I/O port: register file, read path and pad modules
// Functional notes
// - Port has six pins, five two-way and one input only, each with direction, latch and level bits.
// - Direction bit one turns the pin driver off; pin is an input.
// - Direction bit zero turns the driver on, driving the latch bit.
// - Pin three is input only; its direction bit always reads one.
// - Level register reads sampled pins; latch register reads stored latch.
// - Writes to level or latch register both update the output latch.
// - Bit writes via levels read pins, modify bits, store into latch.
// - Analog select bit set disables that pin's digital input buffer.
// - Analog input functions are active only while the pin is analog.
// - Analog select does not affect digital output drive from latch or peripheral.
// - Enabled analog output overrides all digital drive, driver off.
// - After reset every pin is driven from its latch; remap chooses others.
// - With a peripheral on a pin the latch does not drive; still readable.
// - An analog pin reads zero in the level register.
// - All implemented direction bits reset to one; pins start as inputs.
// - Analog select bits reset to analog; software clears them for digital use.
`timescale 1ns/1ns
module gpio_port
  import gpio_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [DATA_W-1:0] o_rdata,
  input wire logic [PIN_W-1:0] i_pin_in,
  output logic [PIN_W-1:0] o_pin_out,
  output logic [PIN_W-1:0] o_pin_oe,
  input wire logic [PIN_W-1:0] i_periph_out,
  input wire logic [PIN_W-1:0] i_analog_out_en,
  output logic [PIN_W-1:0] o_analog_active,
  output logic [PIN_W-1:0] o_periph_in
);

  // Pad-side carrier
  pad_if pads ();

  port_state_t state_reg;
  port_state_t state_next;

  // Write payload cut to the pin width
  logic [PIN_W-1:0] wbits;
  assign wbits = i_wdata[PIN_W-1:0];

  // Read word for the addressed register, upper bits zero
  logic [PIN_W-1:0] read_bits;

  always_comb begin
    case (i_addr)
      OFS_PIN_LEVELS: begin
        read_bits = pads.levels;
      end
      OFS_OUTPUT_LATCH: begin
        read_bits = state_reg.latch;
      end
      OFS_DIRECTION: begin
        read_bits = state_reg.direction | INPUT_ONLY_MASK;
      end
      OFS_ANALOG_SELECT: begin
        read_bits = state_reg.analog_sel;
      end
      OFS_REMAP_SELECT: begin
        read_bits = state_reg.remap_sel;
      end
      default: begin
        read_bits = '0;
      end
    endcase
  end

  // Register file update and registered read data
  always_comb begin
    state_next = state_reg;
    state_next.rdata = READ_DATA_RESET;
    if (i_rd) begin
      state_next.rdata = {{(DATA_W-PIN_W){1'b0}}, read_bits};
    end
    if (i_wr) begin
      case (i_addr)
        OFS_PIN_LEVELS: begin
          state_next.latch = wbits;
        end
        OFS_OUTPUT_LATCH: begin
          state_next.latch = wbits;
        end
        OFS_LEVELS_SET: begin
          state_next.latch = pads.levels | wbits;
        end
        OFS_LEVELS_CLEAR: begin
          state_next.latch = pads.levels & ~wbits;
        end
        OFS_DIRECTION: begin
          state_next.direction = wbits | INPUT_ONLY_MASK;
        end
        OFS_ANALOG_SELECT: begin
          state_next.analog_sel = wbits;
        end
        OFS_REMAP_SELECT: begin
          state_next.remap_sel = wbits;
        end
        default: begin
          state_next.latch = state_reg.latch;
        end
      endcase
    end
    // Analog input functions follow the analog select bits
    state_next.analog_active = state_next.analog_sel;
  end

  // State register, reset to inputs, analog mode and latch drive
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state_reg.latch <= OUTPUT_LATCH_RESET;
      state_reg.direction <= DIRECTION_RESET;
      state_reg.analog_sel <= ANALOG_SELECT_RESET;
      state_reg.remap_sel <= REMAP_SELECT_RESET;
      state_reg.analog_active <= ANALOG_SELECT_RESET;
      state_reg.rdata <= READ_DATA_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  // Controls handed to the pad modules
  assign pads.direction = state_reg.direction;
  assign pads.latch = state_reg.latch;
  assign pads.remap_sel = state_reg.remap_sel;
  assign pads.analog_sel = state_reg.analog_sel;

  // Synchronised pin levels; analog pins come through as zero
  pin_sampler u_sampler (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_pin_in(i_pin_in),
    .pads(pads)
  );

  // Output driver with latch, peripheral and analog priority
  pin_driver u_driver (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_periph_out(i_periph_out),
    .i_analog_out_en(i_analog_out_en),
    .pads(pads),
    .o_pin_out(o_pin_out),
    .o_pin_oe(o_pin_oe)
  );

  // Outputs straight from flip-flops
  assign o_rdata = state_reg.rdata;
  assign o_analog_active = state_reg.analog_active;
  assign o_periph_in = pads.levels;

endmodule : gpio_port

/* File: gpio_port_chk.sv */
// Port-level assertions for the I/O port
`timescale 1ns/1ns
module gpio_port_chk
  import gpio_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [DATA_W-1:0] o_rdata,
  input wire logic [PIN_W-1:0] i_pin_in,
  input wire logic [PIN_W-1:0] o_pin_oe,
  input wire logic [PIN_W-1:0] i_analog_out_en,
  input wire logic [PIN_W-1:0] o_analog_active,
  input wire logic [PIN_W-1:0] o_periph_in
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  // Driver and read path relations
  pin3_undriven_a: assert property (!o_pin_oe[INPUT_ONLY_BIT])
    else $error("pin three driven");
  aout_blocks_a: assert property ((o_pin_oe & $past(i_analog_out_en)) == '0)
    else $error("driver on under analog output");
  rdata_idle_a: assert property (!$past(i_rd) |-> o_rdata == '0)
    else $error("read data outside read cycle");
  rdata_top_a: assert property (o_rdata[7:6] == 2'b00)
    else $error("read data top bits set");
  dir_bit3_a: assert property (i_rd && i_addr == OFS_DIRECTION |=> o_rdata[3])
    else $error("direction bit three reads zero");
  latch_back_a: assert property (i_wr && i_addr == OFS_OUTPUT_LATCH ##2 i_rd &&
    i_addr == OFS_OUTPUT_LATCH |=> o_rdata[5:0] == $past(i_wdata[5:0], 3))
    else $error("latch readback wrong");
  reset_state_a: assert property ($rose(i_nrst) |-> o_pin_oe == '0 &&
    o_analog_active == 6'h3F) else $error("reset state wrong");
  analog_zero_a: assert property ((o_periph_in & o_analog_active &
    $past(o_analog_active) & $past(o_analog_active, 2)) == '0)
    else $error("analog pin reads one");
  sync_delay_a: assert property ($past(i_nrst, 2) |->
    o_periph_in == ($past(i_pin_in, 2) & ~$past(o_analog_active, 2)))
    else $error("pin sync delay wrong");
  // Main scenarios
  cover property (i_wr && i_addr == OFS_LEVELS_SET);
  cover property (|o_pin_oe);
  cover property (|i_analog_out_en);
endmodule : gpio_port_chk
bind gpio_port gpio_port_chk u_chk (.*);

/* File: pin_pad_model.sv */
// Pad-side model of the two-way pins
`timescale 1ns/1ns
module pin_pad_model
  import gpio_pkg::*;
(
  input wire logic [PIN_W-1:0] i_pin_out,
  input wire logic [PIN_W-1:0] i_pin_oe,
  input wire logic [PIN_W-1:0] i_ext_level,
  output logic [PIN_W-1:0] o_pin_in
);
  // Driven pins show the port value, released pins the outside level
  assign o_pin_in = (i_pin_oe & i_pin_out) | (~i_pin_oe & i_ext_level);
endmodule : pin_pad_model

/* File: test_general_purpose_io_port.sv */
// Self-checking bench for the I/O port
`timescale 1ns/1ns
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin mismatches++; \
  $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module test_general_purpose_io_port;
  import gpio_pkg::*;
  logic i_clk, i_nrst, i_wr, i_rd;
  logic [ADDR_W-1:0] i_addr;
  logic [DATA_W-1:0] i_wdata, o_rdata, q;
  logic [PIN_W-1:0] i_pin_in, o_pin_out, o_pin_oe, i_periph_out, i_analog_out_en;
  logic [PIN_W-1:0] o_analog_active, o_periph_in, ext;
  int mismatches, n_compared, cycles;
  gpio_port u_dut (.*);
  pin_pad_model u_pad (.i_pin_out(o_pin_out), .i_pin_oe(o_pin_oe), .i_ext_level(ext),
    .o_pin_in(i_pin_in));
  // Clock and hang guard
  initial begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 2000) begin
      mismatches++;
      test_done();
    end
  end
  // Register port tasks
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask : wr
  task automatic rdc(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 q = o_rdata;
    `CHK($sformatf("read %0h", a), e, q)
  endtask : rdc
  task automatic settle();
    repeat (4) @(posedge i_clk);
    #1;
  endtask : settle
  task automatic test_done();
    if (mismatches == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : test_done
  // Main sequence
  initial begin
    i_nrst = 1'b0;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_addr = '0;
    i_wdata = '0;
    i_periph_out = 6'h05;
    i_analog_out_en = '0;
    ext = 6'h3F;
    repeat (10) @(posedge i_clk);
    i_nrst <= 1'b1;
    rdc(OFS_DIRECTION, 8'h3F);
    rdc(OFS_ANALOG_SELECT, 8'h3F);
    rdc(OFS_OUTPUT_LATCH, 8'h00);
    rdc(OFS_PIN_LEVELS, 8'h00);
    wr(3'h7, 8'hFF);
    rdc(3'h7, 8'h00);
    wr(OFS_ANALOG_SELECT, 8'h00);
    wr(OFS_DIRECTION, 8'h00);
    rdc(OFS_DIRECTION, 8'h08);
    wr(OFS_OUTPUT_LATCH, 8'h15);
    rdc(OFS_OUTPUT_LATCH, 8'h15);
    settle();
    `CHK("oe", 6'h37, o_pin_oe)
    `CHK("out", 6'h15, o_pin_out & o_pin_oe)
    rdc(OFS_PIN_LEVELS, 8'h1D);
    wr(OFS_PIN_LEVELS, 8'h2A);
    rdc(OFS_OUTPUT_LATCH, 8'h2A);
    // Pin three held low outside, so set and clear must see pin levels
    @(posedge i_clk);
    ext <= 6'h37;
    settle();
    rdc(OFS_PIN_LEVELS, 8'h22);
    wr(OFS_LEVELS_SET, 8'h01);
    rdc(OFS_OUTPUT_LATCH, 8'h23);
    settle();
    wr(OFS_LEVELS_CLEAR, 8'h21);
    rdc(OFS_OUTPUT_LATCH, 8'h02);
    wr(OFS_ANALOG_SELECT, 8'h3F);
    settle();
    rdc(OFS_PIN_LEVELS, 8'h00);
    `CHK("aact", 6'h3F, o_analog_active)
    `CHK("oe", 6'h37, o_pin_oe)
    wr(OFS_REMAP_SELECT, 8'h3F);
    settle();
    `CHK("periph", 6'h05, o_pin_out & o_pin_oe)
    wr(OFS_ANALOG_SELECT, 8'h00);
    settle();
    rdc(OFS_PIN_LEVELS, 8'h05);
    `CHK("pin_sync", 6'h05, o_periph_in)
    @(posedge i_clk);
    i_analog_out_en <= 6'h3F;
    settle();
    `CHK("oe", 6'h00, o_pin_oe)
    @(posedge i_clk);
    i_analog_out_en <= 6'h00;
    wr(OFS_DIRECTION, 8'h3F);
    settle();
    `CHK("oe", 6'h00, o_pin_oe)
    test_done();
  end
endmodule : test_general_purpose_io_port
